// file: verilog/adcop_pkg.sv
// Purpose: Shared constants for the converter output and control port
// Assumes: Single 20 MHz system clock, sample clock arrives as a pin
// Notes:   Control word layout is local to this block
package adcop_pkg;
  localparam int unsigned ADCOP_DATA_W       = 10;
  localparam int unsigned ADCOP_LATENCY      = 3;
  localparam int unsigned ADCOP_FIFO_DEPTH   = 8;
  localparam logic [9:0]  ADCOP_CODE_MIN     = 10'h000;
  localparam logic [9:0]  ADCOP_CODE_MAX     = 10'h3FF;
  localparam logic [9:0]  ADCOP_MSB_FLIP     = 10'h200;
  // Control word: bits 9:8 select register, bits 7:0 payload
  localparam int unsigned ADCOP_SEL_HI       = 9;
  localparam int unsigned ADCOP_SEL_LO       = 8;
  localparam logic [1:0]  ADCOP_SEL_CTRL     = 2'h0;
  localparam logic [1:0]  ADCOP_SEL_CLAMP_LO = 2'h1;
  localparam logic [1:0]  ADCOP_SEL_CLAMP_HI = 2'h2;
  // Control register fields
  localparam int unsigned ADCOP_FMT_BIT      = 0;
  localparam int unsigned ADCOP_PD_BIT       = 1;
  localparam int unsigned ADCOP_CLSRC_BIT    = 2;
  localparam int unsigned ADCOP_GAIN_LO      = 3;
  localparam int unsigned ADCOP_GAIN_HI      = 5;
  // Gain code g means gain (g+1)*0.5; code 1 is unity
  localparam logic [2:0]  ADCOP_GAIN_RST     = 3'h1;
  localparam logic [9:0]  ADCOP_CLAMP_RST    = 10'h000;
endpackage

// file: verilog/adcop_fifo.sv
// Purpose: Small flip-flop FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes:   Full refuses writes, empty holds output invalid
`timescale 1ns/1ps
module adcop_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  logic             push;
  logic             pop;
  assign o_ready = (wr_ff - rd_ff) != AW'(0) + (AW+1)'(DEPTH);
  assign o_valid = wr_ff != rd_ff;
  assign o_data  = mem_ff[rd_ff[AW-1:0]];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop)  rd_ff <= rd_ff + 1'b1;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (push) mem_ff[wr_ff[AW-1:0]] <= i_data;
  end
endmodule // adcop_fifo

// file: verilog/adcop_port.sv
// Purpose: Output pipeline and control port of a 10-bit sampling converter
// Assumes: Sample clock, enable, strobes and bus inputs are asynchronous pins
// Notes:   Reference-mode input is synchronised and passed to o_ref_mode every cycle
// What this block does
// - Sample each sample-clock rise, present code after third later rise.
// - Drive bus only while active-low output enable is asserted.
// - With outputs off, latch bus word into control on write strobe.
// - Control holds clamp, format, gain and power-down settings.
// - Output straight binary or two's complement per format bit.
// - Out-of-range flag high when converted sample is below or above range.
// - Saturate: below range gives 0 (-512 in two's complement), above range gives 1023 (511 in two's complement).
// - Gain defaults to unity, programmable 0.5 to 4.0.
// - Clamp level from internal 10-bit DAC or external level input.
// - After reset clamp level comes from external level input.
// - While clamp strobe high, force input to clamp level.
`timescale 1ns/1ps
module adcop_port
  import adcop_pkg::*;
#(
  parameter int unsigned DEPTH = ADCOP_FIFO_DEPTH
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_sample_clk,
  input  wire logic [9:0] i_core_code,
  input  wire logic       i_core_under,
  input  wire logic       i_core_over,
  input  wire logic       i_out_en_n,
  input  wire logic       i_wr_strobe,
  input  wire logic [9:0] i_bus_in,
  input  wire logic       i_clamp_strobe,
  input  wire logic [1:0] i_ref_mode,
  output logic      [9:0] o_bus_out,
  output logic            o_bus_oe_n,
  output logic            o_out_of_range_flag,
  output logic            o_fmt_twos,
  output logic      [2:0] o_gain_code,
  output logic            o_power_down,
  output logic            o_clamp_use_dac,
  output logic      [9:0] o_clamp_dac,
  output logic            o_clamp_active,
  output logic      [1:0] o_ref_mode
);
  ////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [2:0] sclk_s_ff;
  logic [1:0] oen_s_ff;
  logic [2:0] wr_s_ff;
  logic [1:0] clp_s_ff;
  logic [9:0] bus_s1_ff, bus_s2_ff;
  logic [9:0] code_s1_ff, code_s2_ff;
  logic [1:0] und_s_ff, ovr_s_ff;
  logic [1:0] ref_s1_ff, ref_s2_ff;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sclk_s_ff <= '0; oen_s_ff <= 2'b11; wr_s_ff <= '0; clp_s_ff <= '0;
      bus_s1_ff <= '0; bus_s2_ff <= '0; code_s1_ff <= '0; code_s2_ff <= '0;
      und_s_ff <= '0; ovr_s_ff <= '0; ref_s1_ff <= '0; ref_s2_ff <= '0;
    end else begin
      sclk_s_ff  <= {sclk_s_ff[1:0], i_sample_clk};
      oen_s_ff   <= {oen_s_ff[0], i_out_en_n};
      wr_s_ff    <= {wr_s_ff[1:0], i_wr_strobe};
      clp_s_ff   <= {clp_s_ff[0], i_clamp_strobe};
      bus_s1_ff  <= i_bus_in;      bus_s2_ff  <= bus_s1_ff;
      code_s1_ff <= i_core_code;   code_s2_ff <= code_s1_ff;
      und_s_ff   <= {und_s_ff[0], i_core_under};
      ovr_s_ff   <= {ovr_s_ff[0], i_core_over};
      ref_s1_ff  <= i_ref_mode;    ref_s2_ff  <= ref_s1_ff;
    end
  end
  logic sclk_rise;
  logic wr_rise;
  assign sclk_rise = sclk_s_ff[1] && !sclk_s_ff[2];
  assign wr_rise   = wr_s_ff[1] && !wr_s_ff[2];

  ////////////////////////////////////////////////////////////////////
  // Control registers
  logic       fmt_ff, pd_ff, clsrc_ff;
  logic [2:0] gain_ff;
  logic [9:0] clamp_ff;
  logic [1:0] sel;
  assign sel = bus_s2_ff[ADCOP_SEL_HI:ADCOP_SEL_LO];
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fmt_ff   <= 1'b0;
      pd_ff    <= 1'b0;
      clsrc_ff <= 1'b0;
      gain_ff  <= ADCOP_GAIN_RST;
      clamp_ff <= ADCOP_CLAMP_RST;
    end else if (wr_rise && oen_s_ff[1]) begin
      unique case (sel)
        ADCOP_SEL_CTRL: begin
          fmt_ff   <= bus_s2_ff[ADCOP_FMT_BIT];
          pd_ff    <= bus_s2_ff[ADCOP_PD_BIT];
          clsrc_ff <= bus_s2_ff[ADCOP_CLSRC_BIT];
          gain_ff  <= bus_s2_ff[ADCOP_GAIN_HI:ADCOP_GAIN_LO];
        end
        ADCOP_SEL_CLAMP_LO: clamp_ff[7:0] <= bus_s2_ff[7:0];
        ADCOP_SEL_CLAMP_HI: clamp_ff[9:8] <= bus_s2_ff[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pipeline: three sample-clock rises to output
  logic [10:0] pipe_ff [ADCOP_LATENCY];
  logic [9:0]  sat_code;
  logic        oor;
  always_comb begin
    oor      = und_s_ff[1] || ovr_s_ff[1];
    sat_code = und_s_ff[1] ? ADCOP_CODE_MIN : (ovr_s_ff[1] ? ADCOP_CODE_MAX : code_s2_ff);
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      for (int i = 0; i < ADCOP_LATENCY; i++) pipe_ff[i] <= '0;
    end else if (sclk_rise) begin
      pipe_ff[0] <= {oor, sat_code};
      for (int i = 1; i < ADCOP_LATENCY; i++) pipe_ff[i] <= pipe_ff[i-1];
    end
  end
  logic sclk_rise_d_ff;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) sclk_rise_d_ff <= 1'b0;
    else sclk_rise_d_ff <= sclk_rise;
  end

  ////////////////////////////////////////////////////////////////////
  // Output FIFO
  logic [10:0] f_data;
  logic        f_valid, f_ready, in_ready;
  adcop_fifo #(.WIDTH(11), .DEPTH(DEPTH)) u_fifo (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_data    (pipe_ff[ADCOP_LATENCY-1]),
    .i_valid   (sclk_rise_d_ff && !pd_ff),
    .o_ready   (in_ready),
    .o_data    (f_data),
    .o_valid   (f_valid),
    .i_ready   (f_ready)
  );
  // Drain one word per sample rise while driving; stall while disabled
  assign f_ready = sclk_rise && !oen_s_ff[1];

  ////////////////////////////////////////////////////////////////////
  // Output drive
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_bus_out           <= '0;
      o_bus_oe_n          <= 1'b1;
      o_out_of_range_flag <= 1'b0;
    end else begin
      o_bus_oe_n <= oen_s_ff[1];
      if (f_valid && f_ready) begin
        o_bus_out           <= fmt_ff ? (f_data[9:0] ^ ADCOP_MSB_FLIP) : f_data[9:0];
        o_out_of_range_flag <= f_data[10];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Analog control outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_fmt_twos <= 1'b0; o_gain_code <= ADCOP_GAIN_RST; o_power_down <= 1'b0;
      o_clamp_use_dac <= 1'b0; o_clamp_dac <= ADCOP_CLAMP_RST; o_clamp_active <= 1'b0;
      o_ref_mode <= '0;
    end else begin
      o_fmt_twos      <= fmt_ff;
      o_gain_code     <= gain_ff;
      o_power_down    <= pd_ff;
      o_clamp_use_dac <= clsrc_ff;
      o_clamp_dac     <= clamp_ff;
      o_clamp_active  <= clp_s_ff[1];
      o_ref_mode      <= ref_s2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions
  property p_oe_follow;
    @(posedge i_clk_sys) disable iff (i_rst) 1'b1 |=> o_bus_oe_n == $past(oen_s_ff[1]);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("oe not following enable");
  property p_no_write_when_on;
    @(posedge i_clk_sys) disable iff (i_rst) (wr_rise && !oen_s_ff[1]) |=> $stable(gain_ff) && $stable(fmt_ff);
  endproperty
  a_no_write_when_on: assert property (p_no_write_when_on) else $error("write taken while driving");
  property p_ctrl_write;
    @(posedge i_clk_sys) disable iff (i_rst) (wr_rise && oen_s_ff[1] && sel == ADCOP_SEL_CTRL)
      |=> gain_ff == $past(bus_s2_ff[ADCOP_GAIN_HI:ADCOP_GAIN_LO]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("gain not latched");
  property p_fmt;
    @(posedge i_clk_sys) disable iff (i_rst) (f_valid && f_ready && fmt_ff) |=> o_bus_out[9] != $past(f_data[9]);
  endproperty
  a_fmt: assert property (p_fmt) else $error("twos format not applied");
  property p_sat_hi;
    @(posedge i_clk_sys) disable iff (i_rst) (ovr_s_ff[1] && !und_s_ff[1]) |-> sat_code == 10'h3FF && oor;
  endproperty
  a_sat_hi: assert property (p_sat_hi) else $error("no high saturation");
  property p_sat_lo;
    @(posedge i_clk_sys) disable iff (i_rst) und_s_ff[1] |-> sat_code == 10'h000;
  endproperty
  a_sat_lo: assert property (p_sat_lo) else $error("no low saturation");
  property p_pipe;
    @(posedge i_clk_sys) disable iff (i_rst) sclk_rise |=> pipe_ff[1] == $past(pipe_ff[0]);
  endproperty
  a_pipe: assert property (p_pipe) else $error("pipeline not shifting");
  property p_clamp;
    @(posedge i_clk_sys) disable iff (i_rst) clp_s_ff[1] |=> o_clamp_active;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp not active");
  property p_reset_src;
    @(posedge i_clk_sys) $fell(i_rst) |-> !clsrc_ff && gain_ff == 3'h1;
  endproperty
  a_reset_src: assert property (p_reset_src) else $error("bad reset defaults");
  c_write: cover property (@(posedge i_clk_sys) wr_rise && oen_s_ff[1]);
  c_drain: cover property (@(posedge i_clk_sys) f_valid && f_ready);
  c_full:  cover property (@(posedge i_clk_sys) !in_ready);
endmodule // adcop_port

// file: test/adcop_host.sv
// Purpose: Host model driving output enable and control writes
// Assumes: Changes its pins on the falling system clock edge
// Notes:   Released bus shows the inverse of the last word
`timescale 1ns/1ps
module adcop_host (
  input  wire logic       i_clk_sys,
  output logic            o_out_en_n,
  output logic            o_wr_strobe,
  output logic      [9:0] o_bus
);
  initial begin
    o_out_en_n  = 1'b1;
    o_wr_strobe = 1'b0;
    o_bus       = 10'h000;
  end
  task automatic set_en(input logic en);
    @(negedge i_clk_sys) o_out_en_n = ~en;
    repeat (4) @(negedge i_clk_sys);
  endtask
  task automatic write(input logic [9:0] word);
    @(negedge i_clk_sys) o_bus = word;
    repeat (2) @(negedge i_clk_sys);
    o_wr_strobe = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    o_wr_strobe = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    o_bus = ~word;
    repeat (4) @(negedge i_clk_sys);
  endtask
endmodule // adcop_host

// file: test/tb_adcop_port.sv
// Purpose: Self-checking bench for the converter output and control port
// Assumes: Inputs change on the falling clock edge
// Notes:   Scoreboard pairs each new bus word with its sample
`timescale 1ns/1ps
module tb_adcop_port
  import adcop_pkg::*;
;
  logic        clk, rst, smp, under, over, clamp, en_n, wr, fmt_b;
  logic [9:0]  code, bus_in, bus_out, dac, last;
  logic [1:0]  ref_i, ref_o;
  logic [2:0]  gain;
  logic        oe_n, flag, fmt, pd, use_dac, clamp_act;
  logic [10:0] prev, ctl;
  logic [10:0] expq[$];
  int          mismatches, checked;
  assign ctl = {5'h00, gain, use_dac, pd, fmt};
  adcop_port u_dut (.i_clk_sys(clk), .i_rst(rst), .i_sample_clk(smp), .i_core_code(code),
    .i_core_under(under), .i_core_over(over), .i_out_en_n(en_n), .i_wr_strobe(wr), .i_bus_in(bus_in),
    .i_clamp_strobe(clamp), .i_ref_mode(ref_i), .o_bus_out(bus_out), .o_bus_oe_n(oe_n),
    .o_out_of_range_flag(flag), .o_fmt_twos(fmt), .o_gain_code(gain), .o_power_down(pd),
    .o_clamp_use_dac(use_dac), .o_clamp_dac(dac), .o_clamp_active(clamp_act), .o_ref_mode(ref_o));
  adcop_host u_host (.i_clk_sys(clk), .o_out_en_n(en_n), .o_wr_strobe(wr), .o_bus(bus_in));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [10:0] seen, input logic [10:0] want);
    checked++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [10:0] expect_word(logic [9:0] c, logic u, logic o, logic tw);
    logic [9:0] s;
    s = u ? ADCOP_CODE_MIN : (o ? ADCOP_CODE_MAX : c);
    return {u | o, s ^ (tw ? ADCOP_MSB_FLIP : 10'h000)};
  endfunction
  task automatic do_reset();
    @(negedge clk) rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    expq.delete();
    last  = 10'h000;
    prev  = 11'h000;
    fmt_b = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic sample(input int n, input logic lat);
    logic [10:0] e;
    for (int k = 0; k < n; k++) begin
      do begin
        code  = 10'($urandom);
        under = ($urandom % 8) == 0;
        over  = !under && ($urandom % 8) == 0;
        e     = expect_word(code, under, over, fmt_b);
      end while (e[9:0] == prev[9:0]);
      prev = e;
      expq.push_back(e);
      repeat (8) @(negedge clk);
      if (lat && k >= 4) check(11'(expq.size()), 11'h004);
      smp = 1'b1;
      repeat (8) @(negedge clk);
      smp = 1'b0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (!rst && bus_out !== last) begin
      last = bus_out;
      if (expq.size() == 0) check({flag, bus_out}, ~{flag, bus_out});
      else check({flag, bus_out}, expq.pop_front());
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    summarize();
  end
  initial begin
    logic [2:0] r;
    logic [7:0] lo;
    logic [1:0] hi;
    int         i;
    rst = 1'b1;
    void'($urandom(1));
    {smp, under, over, clamp} = '0;
    code  = 10'($urandom);
    ref_i = 2'($urandom % 3);
    do_reset();
    check({oe_n, flag, clamp_act, ctl[7:0]}, {3'b100, 2'b00, ADCOP_GAIN_RST, 3'b000});
    check({1'b0, dac}, {1'b0, ADCOP_CLAMP_RST});
    u_host.set_en(1'b1);
    check({10'h000, oe_n}, 11'h000);
    sample(12, 1'b1);
    u_host.set_en(1'b0);
    check({10'h000, oe_n}, 11'h001);
    // Fill the buffer to its full depth while outputs are off (pipeline words included), then drain
    sample(ADCOP_FIFO_DEPTH - 1, 1'b0);
    u_host.set_en(1'b1);
    // Each rise drains one word, so the backlog stays behind the pipeline
    sample(4, 1'b0);
    check(11'(expq.size()), 11'(ADCOP_FIFO_DEPTH + ADCOP_LATENCY - 1));
    u_host.set_en(1'b0);
    for (i = 0; i < 8; i++) begin
      r = 3'($urandom);
      u_host.write({ADCOP_SEL_CTRL, 2'b00, 3'(i), r});
      check(ctl, {5'h00, 3'(i), r});
    end
    lo = 8'($urandom);
    hi = 2'($urandom);
    u_host.write({ADCOP_SEL_CLAMP_LO, lo});
    u_host.write({ADCOP_SEL_CLAMP_HI, 6'h00, hi});
    u_host.write({2'h3, 8'hFF});
    check({1'b0, dac}, {1'b0, hi, lo});
    check(ctl, {5'h00, 3'h7, r});
    u_host.set_en(1'b1);
    u_host.write({ADCOP_SEL_CTRL, 8'h00});
    check(ctl, {5'h00, 3'h7, r});
    for (i = 0; i < 4; i++) begin
      @(negedge clk) clamp = i[0];
      ref_i = 2'(i % 3);
      repeat (5) @(negedge clk);
      check({8'h00, clamp_act, ref_o}, {8'h00, i[0], 2'(i % 3)});
    end
    do_reset();
    u_host.set_en(1'b0);
    u_host.write({ADCOP_SEL_CTRL, 2'b00, ADCOP_GAIN_RST, 3'b001});
    fmt_b = 1'b1;
    // Reset contents of the pipeline show up as one visible word
    prev  = expect_word(ADCOP_CODE_MIN, 1'b0, 1'b0, fmt_b);
    expq.push_back(prev);
    u_host.set_en(1'b1);
    sample(12, 1'b1);
    summarize();
  end
endmodule // tb_adcop_port
